// File: include/stfe_pkg.sv
package stfe_pkg;
   // Register indices on the plain port
   localparam logic [1:0] ADDR_CTRL = 2'h0;
   localparam logic [1:0] ADDR_STAT = 2'h1;
   localparam logic [1:0] ADDR_DATA = 2'h2;
   // Control register field positions
   localparam int CTRL_SPRIE_POS = 7;
   localparam int CTRL_ERRIE_POS = 6;
   localparam int CTRL_MASTER_POS = 5;
   localparam int CTRL_CLOCK_POLARITY_SELECT_POS = 4;
   localparam int CTRL_CLOCK_PHASE_SELECT_POS = 3;
   localparam int CTRL_ENABLE_POS = 1;
   localparam int CTRL_MODFEN_POS = 0;
   // Status register field positions
   localparam int STAT_RXFULL_POS = 7;
   localparam int STAT_OVR_POS = 6;
   localparam int STAT_MODE_FAULT_FLAG_POS = 4;
   localparam int STAT_TXEMPTY_POS = 3;
   localparam int STAT_RATE_POS = 0;
   // Reset values
   localparam logic [7:0] CTRL_RESET = 8'h08;
   localparam logic [1:0] RATE_RESET = 2'h0;
   localparam logic [7:0] DATA_RESET = 8'h00;
   // Half bit times in bus cycles per rate setting
   localparam logic [6:0] HALF_DIV_2 = 7'h01;
   localparam logic [6:0] HALF_DIV_8 = 7'h04;
   localparam logic [6:0] HALF_DIV_32 = 7'h10;
   localparam logic [6:0] HALF_DIV_128 = 7'h40;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   // Rate encodings
   typedef enum logic [1:0] {
      rate_div_2,
      rate_div_8,
      rate_div_32,
      rate_div_128
   } stfe_rate_t;
   // Serial pins from outside
   typedef struct packed {
      logic sck;
      logic mosi;
      logic miso;
      logic ss_n;
   } stfe_pins_in_t;
   // Serial pins driven with enables
   typedef struct packed {
      logic sck;
      logic sck_oe;
      logic mosi;
      logic mosi_oe;
      logic miso;
      logic miso_oe;
   } stfe_pins_out_t;
endpackage

// File: src/stfe_engine.sv
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
// Function
// RULE1: Slave drives MISO only while selected
// RULE2: Phase 0 first edge captures MSB
// RULE3: Master toggles select between phase-0 bytes
// RULE4: Phase-0 slave starts on select fall
// RULE5: No buffer load during slave transfer
// RULE6: Phase 1 first edge starts transfer
// RULE7: Phase-1 slave accepts bytes select low
// RULE8: Master own select held high externally
// RULE9: Master data write starts transfer
// RULE10: Bit clock runs only enabled master
// RULE11: Clock edges mid bus-clock low phase (here: on the bus-clock rising edge)
// RULE12: Start delay at most one bit time
// RULE13: Queued byte sent right after previous
// RULE14: Host writes data only when empty
// RULE15: Buffer load sets, write clears empty
// RULE16: Done byte sets full, read sequence clears
// RULE17: No new byte resends shift contents
// RULE18: Empty flag back within two cycles
// RULE19: Active slave reload waits transfer end
// RULE20: Unread receive sets overrun, keeps old
// RULE21: Select level conflicting role sets fault
// RULE22: Disable before changing phase, polarity
// RULE23: Polarity sets only clock idle level
// RULE24: Master bit selects role, clock direction
// RULE25: Overrun checked at bit-1 capture
// RULE26: Select high floats MISO, ignores clocks
// RULE27: Eight bits MSB first, opposite edges
module stfe_engine (
   input wire logic core_clk_i, // Bus clock
   input wire logic srst_i, // Synchronous reset
   input wire logic [1:0] reg_addr_i, // Register index
   input wire logic [7:0] reg_wdata_i, // Write data
   input wire logic reg_wr_i, // Write strobe
   input wire logic reg_rd_i, // Read strobe
   output logic [7:0] reg_rdata_o, // Read data, cycle after strobe
   input wire stfe_pkg::stfe_pins_in_t pins_i, // Serial pins in
   output stfe_pkg::stfe_pins_out_t pins_o // Serial pins out
);
   import stfe_pkg::*;

   // Control and status state
   logic [7:0] ctrl_q; // Control register
   logic [1:0] rate_q; // Rate select field
   logic [7:0] txbuf_q; // Transmit buffer
   logic txe_q; // Transmit buffer empty flag
   logic [7:0] rxbuf_q; // Receive register
   logic rxf_q; // Receive full flag
   logic ovr_q; // Overrun flag
   logic mode_fault_flag_q; // Mode fault flag
   logic rxf_armed_q; // Status read seen with full set
   logic ovr_armed_q; // Status read seen with overrun set
   logic mode_fault_flag_armed_q; // Status read seen with fault set
   logic [7:0] rdata_q; // Registered read data
   // Shift engine state
   logic [7:0] shift_q; // Shift register
   logic [3:0] bitcnt_q; // Bits captured so far
   logic active_q; // Transfer in progress
   logic sck_q; // Generated clock level
   logic mosi_q; // Master data out
   logic miso_q; // Slave data out
   logic [6:0] div_q; // Free-running divider
   logic m_pend_q; // Master byte loaded, waiting for the divider
   logic [1:0] ss_sync_q, sck_sync_q, mosi_sync_q, miso_sync_q; // Pin synchronisers
   logic ss_d1_q, sck_d1_q; // Previous synced levels for edges

   // Control fields
   wire enable = ctrl_q[CTRL_ENABLE_POS];
   wire master = ctrl_q[CTRL_MASTER_POS];
   wire clock_polarity_select = ctrl_q[CTRL_CLOCK_POLARITY_SELECT_POS];
   wire clock_phase_select = ctrl_q[CTRL_CLOCK_PHASE_SELECT_POS];
   wire modfen = ctrl_q[CTRL_MODFEN_POS];

   // Synchronised pins; only stage 1 is read by logic
   wire ss_s = ss_sync_q[1];
   wire sck_s = sck_sync_q[1];
   wire mosi_s = mosi_sync_q[1];
   wire miso_s = miso_sync_q[1];

   // Register decodes
   wire wr_ctrl = reg_wr_i && (reg_addr_i == ADDR_CTRL);
   wire wr_stat = reg_wr_i && (reg_addr_i == ADDR_STAT);
   wire wr_data = reg_wr_i && (reg_addr_i == ADDR_DATA);
   wire rd_stat = reg_rd_i && (reg_addr_i == ADDR_STAT);
   wire rd_data = reg_rd_i && (reg_addr_i == ADDR_DATA);

   // Divider half period per rate setting
   wire [6:0] half_period = (rate_q == rate_div_2) ? HALF_DIV_2 :
                            (rate_q == rate_div_8) ? HALF_DIV_8 :
                            (rate_q == rate_div_32) ? HALF_DIV_32 : HALF_DIV_128;
   // Bit clock only runs for an enabled master [RULE10]
   wire clk_run = enable && master;
   // Half-bit tick; registered edges land on the bus-clock boundary,
   // the nearest we get to mid-low with a single rising-edge domain [RULE11]
   wire tick = clk_run && (div_q == (half_period - 7'h01));

   // Slave edge detection on synced clock, polarity folded in [RULE23]
   wire sck_act = sck_s ^ clock_polarity_select;
   wire sck_act_d = sck_d1_q ^ clock_polarity_select;
   wire s_lead = sck_act && !sck_act_d; // Idle to active
   wire s_trail = !sck_act && sck_act_d; // Active to idle
   wire ss_fall = ss_d1_q && !ss_s;
   wire ss_rise = !ss_d1_q && ss_s;
   // Slave only listens while selected [RULE26]
   wire slave_on = enable && !master && !ss_s;

   // Capture and launch edges, shared by both roles [RULE27]
   logic m_lead, m_trail; // Master edge strobes from tick
   assign m_lead = tick && active_q && (sck_q == clock_polarity_select);
   assign m_trail = tick && active_q && (sck_q != clock_polarity_select);
   wire lead = master ? m_lead : (slave_on && s_lead);
   wire trail = master ? m_trail : (slave_on && s_trail);
   wire cap = clock_phase_select ? trail : lead; // Capture on second edge in phase 1
   wire launch = clock_phase_select ? lead : trail;
   // Incoming data goes through the pin synchroniser, so a master at the
   // fastest rate captures one bit late; the slower rates leave enough
   // margin between launch and capture to absorb the two flops.
   wire din = master ? miso_s : mosi_s;
   wire last_bit = (bitcnt_q == BITS_PER_BYTE - 4'h1);
   // Transfer ends at return to idle after eighth bit
   // Phase 1 closes on the eighth capture, which returns the clock to idle;
   // phase 0 closes on the trailing edge after the eighth capture
   wire xfer_end = active_q && (clock_phase_select ? (cap && last_bit) :
                   ((bitcnt_q == BITS_PER_BYTE) && (master ? m_trail : s_trail)));
   // Any role or phase: the eighth capture completes the received byte
   wire done_byte = cap && last_bit;

   // Transfer starts by role and phase
   // Master only starts on a divider boundary, so the delay from the
   // write stays inside one bit time whatever the rate [RULE12]
   wire m_start = clk_run && !active_q && m_pend_q && (div_q == 7'h00); // [RULE9] [RULE12] [RULE13]
   wire s_start0 = enable && !master && !clock_phase_select && ss_fall && !active_q; // [RULE4]
   wire s_start1 = slave_on && clock_phase_select && s_lead && !active_q; // [RULE6] [RULE7]
   wire start = m_start || s_start0 || s_start1;
   // Buffer loads shift only when idle [RULE5] [RULE19]
   // An idle engine takes the buffer at once, freeing it for a second
   // byte before the master has even started [RULE18]
   // A master byte loaded but not yet started blocks the next load
   wire load = enable && !active_q && !txe_q && !m_pend_q;
   wire [7:0] next_shift = load ? txbuf_q : shift_q; // Old contents resend [RULE17]

   // Mode faults: master selected low, slave deselected mid-transfer [RULE21]
   wire fault_m = enable && master && !ss_s;
   wire fault_s = enable && !master && ss_rise && active_q;
   wire fault = modfen && (fault_m || fault_s);
   // Overrun seen at the bit-1 capture [RULE25]
   wire ovr_set = cap && (bitcnt_q == 4'h6) && rxf_q;
   wire rx_commit = done_byte && !rxf_q && !ovr_q && !ovr_set; // [RULE20]

   // Read data mux
   logic [7:0] stat_view; // Status byte
   assign stat_view = {rxf_q, ovr_q, 1'b0, mode_fault_flag_q, txe_q, 1'b0, rate_q};
   wire [7:0] rd_mux = (reg_addr_i == ADDR_CTRL) ? ctrl_q :
                       (reg_addr_i == ADDR_STAT) ? stat_view :
                       (reg_addr_i == ADDR_DATA) ? rxbuf_q : 8'h00;

   // Pin synchronisers, two stages each
   always_ff @(posedge core_clk_i) begin
      ss_sync_q <= {ss_sync_q[0], pins_i.ss_n};
      sck_sync_q <= {sck_sync_q[0], pins_i.sck};
      mosi_sync_q <= {mosi_sync_q[0], pins_i.mosi};
      miso_sync_q <= {miso_sync_q[0], pins_i.miso};
      ss_d1_q <= ss_s;
      sck_d1_q <= sck_s;
   end

   // Free-running divider while enabled master
   always_ff @(posedge core_clk_i) begin
      if (srst_i || !clk_run || tick) begin
         div_q <= 7'h00;
      end else begin
         div_q <= div_q + 7'h01;
      end
   end

   // Control, rate and read data registers
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         ctrl_q <= CTRL_RESET;
         rate_q <= RATE_RESET;
         rdata_q <= DATA_RESET;
      end else begin
         rdata_q <= reg_rd_i ? rd_mux : 8'h00;
         if (fault_m && modfen) begin
            ctrl_q[CTRL_ENABLE_POS] <= 1'b0; // Master fault drops enable
         end else if (wr_ctrl) begin
            ctrl_q <= reg_wdata_i;
         end
         if (wr_stat) begin
            rate_q <= reg_wdata_i[STAT_RATE_POS +: 2];
         end
      end
   end

   // Transmit buffer and empty flag [RULE15] [RULE18]
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         txbuf_q <= DATA_RESET;
         txe_q <= 1'b1;
      end else if (wr_data) begin
         txbuf_q <= reg_wdata_i; // Host honours empty flag [RULE14]
         txe_q <= 1'b0;
      end else if (load || (fault_m && modfen)) begin
         txe_q <= 1'b1;
      end
   end

   // Receive register, full and overrun flags [RULE16] [RULE20]
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         rxbuf_q <= DATA_RESET;
         rxf_q <= 1'b0;
         ovr_q <= 1'b0;
         rxf_armed_q <= 1'b0;
         ovr_armed_q <= 1'b0;
      end else begin
         if (rx_commit) begin
            rxbuf_q <= {shift_q[6:0], din};
         end
         // Set wins over the data-read clear
         if (rx_commit) begin
            rxf_q <= 1'b1;
         end else if (rd_data && rxf_armed_q) begin
            rxf_q <= 1'b0;
         end
         if (ovr_set) begin
            ovr_q <= 1'b1;
         end else if (rd_data && ovr_armed_q) begin
            ovr_q <= 1'b0;
         end
         if (rd_stat) begin
            rxf_armed_q <= rxf_q;
            ovr_armed_q <= ovr_q;
         end else if (rd_data) begin
            rxf_armed_q <= 1'b0;
            ovr_armed_q <= 1'b0;
         end
      end
   end

   // Mode fault flag: status read then control write clears
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         mode_fault_flag_q <= 1'b0;
         mode_fault_flag_armed_q <= 1'b0;
      end else begin
         if (fault) begin
            mode_fault_flag_q <= 1'b1; // [RULE21]
         end else if (wr_ctrl && mode_fault_flag_armed_q) begin
            mode_fault_flag_q <= 1'b0;
         end
         if (rd_stat) begin
            mode_fault_flag_armed_q <= mode_fault_flag_q;
         end else if (wr_ctrl || fault) begin
            mode_fault_flag_armed_q <= 1'b0;
         end
      end
   end

   // Shift engine: start, capture, launch, finish
   always_ff @(posedge core_clk_i) begin
      if (srst_i || !enable) begin
         shift_q <= DATA_RESET;
         bitcnt_q <= 4'h0;
         active_q <= 1'b0;
         m_pend_q <= 1'b0;
         sck_q <= 1'b0;
         mosi_q <= 1'b0;
         miso_q <= 1'b0;
      end else begin
         if (!active_q) begin
            sck_q <= clock_polarity_select; // Idle level [RULE23]
         end else if (tick && master) begin
            sck_q <= ~sck_q;
         end
         // Pending start: set by a master load, used up by the start
         if (m_start) begin
            m_pend_q <= 1'b0;
         end else if (load && master) begin
            m_pend_q <= 1'b1;
         end
         if (start) begin
            active_q <= 1'b1;
            bitcnt_q <= 4'h0;
            shift_q <= next_shift;
            if (!clock_phase_select) begin
               mosi_q <= next_shift[7]; // Phase 0: data before first edge [RULE9]
            end
            miso_q <= next_shift[7]; // MSB out at start: ahead of the first edge in phase 0, on it in phase 1 [RULE2] [RULE4] [RULE6]
         end else if (!master && ss_s) begin
            active_q <= 1'b0; // Deselect aborts, clocks ignored [RULE26]
            bitcnt_q <= 4'h0;
            // A load while deselected must still reach the shifter
            shift_q <= next_shift;
         end else begin
            if (!active_q) begin
               shift_q <= next_shift;
            end
            if (cap) begin
               shift_q <= {shift_q[6:0], din}; // MSB first [RULE27]
               bitcnt_q <= bitcnt_q + 4'h1;
            end else if (launch && (bitcnt_q != 4'h0 || clock_phase_select) && bitcnt_q != BITS_PER_BYTE) begin
               mosi_q <= shift_q[7];
               miso_q <= shift_q[7];
            end
            if (xfer_end) begin
               active_q <= 1'b0; // Queued byte may follow [RULE13]
            end
         end
      end
   end

   // Pin drivers: clock and MOSI as master, MISO as selected slave [RULE24]
   assign pins_o.sck = sck_q;
   assign pins_o.sck_oe = enable && master;
   assign pins_o.mosi = mosi_q;
   assign pins_o.mosi_oe = enable && master;
   assign pins_o.miso = miso_q;
   assign pins_o.miso_oe = enable && !master && !ss_s; // [RULE1]
   assign reg_rdata_o = rdata_q;
endmodule

// File: verification/stfe_engine_sva.sv
`timescale 1ns/1ps
// Port-level checks on the engine
module stfe_engine_chk import stfe_pkg::*; (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic [1:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire stfe_pkg::stfe_pins_in_t pins_i,
   input wire stfe_pkg::stfe_pins_out_t pins_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (srst_i);
   logic [7:0] ctrl_q; // Shadow of control writes
   logic [1:0] rate_q; // Shadow of rate field
   wire en_mst = ctrl_q[CTRL_MASTER_POS] & ctrl_q[CTRL_ENABLE_POS];
   wire en_slv = ~ctrl_q[CTRL_MASTER_POS] & ctrl_q[CTRL_ENABLE_POS];
   wire data_wr = reg_wr_i & (reg_addr_i == ADDR_DATA);
   // Shadow misses fault-driven disable, so it only bounds enables
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         ctrl_q <= CTRL_RESET;
         rate_q <= RATE_RESET;
      end else if (reg_wr_i && reg_addr_i == ADDR_CTRL) begin
         ctrl_q <= reg_wdata_i;
      end else if (reg_wr_i && reg_addr_i == ADDR_STAT) begin
         rate_q <= reg_wdata_i[1:0];
      end
   end
   // Four samples high covers the input synchroniser
   chk_miso_float: assert property (pins_i.ss_n [*4] |-> !pins_o.miso_oe)
      else $error("miso driven while deselected");
   chk_miso_role: assert property (pins_o.miso_oe |-> en_slv || $past(en_slv))
      else $error("miso driven outside slave role");
   chk_sck_role: assert property (pins_o.sck_oe |-> en_mst || $past(en_mst))
      else $error("serial clock driven outside master role");
   chk_oe_pair: assert property (!(pins_o.sck_oe && pins_o.miso_oe))
      else $error("master and slave outputs driven together");
   chk_start_lat: assert property (data_wr && en_mst && pins_o.sck_oe && rate_q == 2'h0
      |-> ##[1:8] $changed(pins_o.sck)) else $error("master start too late");
   chk_mosi_launch: assert property (ctrl_q[CTRL_CLOCK_PHASE_SELECT_POS] && pins_o.mosi_oe && $past(pins_o.mosi_oe)
      && $changed(pins_o.mosi) |-> $changed(pins_o.sck)) else $error("mosi moved off a clock edge");
   chk_rd_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
      else $error("read data outside its cycle");
   chk_unmapped_rd: assert property (reg_rd_i && reg_addr_i == 2'h3 |=> reg_rdata_o == 8'h00)
      else $error("unmapped index read nonzero");
   cover property (data_wr && en_mst);
   cover property (pins_o.miso_oe);
   cover property (reg_rd_i && reg_addr_i == ADDR_STAT);
endmodule
bind stfe_engine stfe_engine_chk i_chk (.core_clk_i(core_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
   .pins_i(pins_i), .pins_o(pins_o));

// File: verification/stfe_far_slave.sv
`timescale 1ns/1ps
// Behavioural far-end slave run by the engine's serial clock
module stfe_far_slave (
   input wire logic sck_i, // Serial clock from master
   input wire logic ss_n_i, // Select from bench
   input wire logic mosi_i, // Master data
   input wire logic clock_polarity_select_i, // Clock idle level
   input wire logic clock_phase_select_i, // Clock phase
   input wire logic [7:0] tx_i, // Byte to return
   output logic miso_o, // Data back to master
   output logic [7:0] rx_o // Bits received
);
   logic [7:0] sh = 8'h00; // Outgoing shifter
   int n = 0; // Captures in this byte
   initial miso_o = 1'b0;
   initial rx_o = 8'h00;
   // Selection loads; phase 0 shows the MSB at once
   always @(negedge ss_n_i) begin
      sh = tx_i;
      n = 0;
      if (!clock_phase_select_i) miso_o = sh[7];
   end
   // Released line shows the inverse, never a held value
   always @(posedge ss_n_i) miso_o = ~miso_o;
   // Capture on one edge kind, launch on the other
   always @(sck_i) begin
      if (!ss_n_i && ((sck_i != clock_polarity_select_i) != clock_phase_select_i)) begin
         rx_o = {rx_o[6:0], mosi_i};
         n = n + 1;
      end else if (!ss_n_i) begin
         // Select kept low: next byte follows directly
         if (n == 8) begin
            sh = tx_i;
            n = 0;
         end else if (!clock_phase_select_i) sh = sh << 1;
         miso_o = sh[7];
         if (clock_phase_select_i) sh = sh << 1;
      end
   end
endmodule

// File: verification/stfe_engine_tb.sv
`timescale 1ns/1ps
module stfe_engine_tb;
   import stfe_pkg::*;
   logic core_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic [1:0] reg_addr_i = 2'h0;
   logic [7:0] reg_wdata_i = 8'h00;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [7:0] reg_rdata_o, rv, far_rx, m0, m1, s0, s1;
   logic [7:0] far_tx = 8'h00; // Byte the far slave returns
   stfe_pins_in_t pins_i;
   stfe_pins_out_t pins_o;
   logic lk_sck = 1'b0, lk_mosi = 1'b0;
   logic lk_ss_n = 1'b1; // High while master
   logic sel_n = 1'b1, far_miso, clock_polarity_select = 1'b0, clock_phase_select = 1'b0;
   int errors = 0, cmp_count = 0, seed = 95240;
   always #50 core_clk_i = ~core_clk_i;
   assign pins_i = '{sck: lk_sck, mosi: lk_mosi, miso: far_miso, ss_n: lk_ss_n};
   stfe_engine i_dut (.core_clk_i(core_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .pins_i(pins_i), .pins_o(pins_o));
   stfe_far_slave i_far (.sck_i(pins_o.sck), .ss_n_i(sel_n), .mosi_i(pins_o.mosi), .clock_polarity_select_i(clock_polarity_select), .clock_phase_select_i(clock_phase_select),
      .tx_i(far_tx), .miso_o(far_miso), .rx_o(far_rx));
   // One bus cycle; read data is taken just after the edge
   task automatic bus(input logic w, input logic r, input logic [1:0] a, input logic [7:0] d);
      reg_wr_i <= w;
      reg_rd_i <= r;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge core_clk_i);
      #1 rv = reg_rdata_o;
   endtask
   task automatic idle(input int n);
      repeat (n) bus(1'b0, 1'b0, 2'h0, 8'h00);
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   // Status byte from its flags
   function automatic logic [7:0] stat(input logic f, input logic o, input logic m, input logic t, input logic [1:0] r);
      stat = {f, o, 1'b0, m, t, 1'b0, r};
   endfunction
   // Poll status with a bound; a hang counts as a mismatch
   task automatic poll(input int pos);
      int k;
      k = 0;
      do begin
         bus(1'b0, 1'b1, ADDR_STAT, 8'h00);
         k++;
      end while (rv[pos] !== 1'b1 && k < 3000);
      if (k >= 3000) errors++;
   endtask
   // Far master frame, phase 0, link clock of 800 ns
   task automatic slv(input logic [7:0] sv, input logic [7:0] mv, input logic wr_mid);
      lk_ss_n = 1'b0;
      idle(5);
      chk("slave msb", {1'b1, 6'h00, sv[7]}, {pins_o.miso_oe, 6'h00, pins_o.miso});
      for (int b = 7; b >= 0; b--) begin
         lk_mosi = mv[b];
         #400 lk_sck = 1'b1;
         chk("slave bit", 8'(sv[b]), 8'(pins_o.miso));
         #400 lk_sck = 1'b0;
         if (wr_mid && b == 4) bus(1'b1, 1'b0, ADDR_DATA, 8'h3C);
         if (wr_mid && b == 4) idle(1);
      end
      #400 lk_ss_n = 1'b1;
      idle(5);
      chk("miso released", 8'h00, 8'(pins_o.miso_oe));
      bus(1'b0, 1'b1, ADDR_STAT, 8'h00);
      chk("slave status", stat(1, 0, 0, 1, 2'h3), rv);
      bus(1'b0, 1'b1, ADDR_DATA, 8'h00);
      chk("slave rx", mv, rv);
   endtask
   task automatic conclude();
      $display("errors %0d, comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #3000000;
      errors++;
      conclude();
   end
   initial begin
      repeat (20) @(posedge core_clk_i);
      srst_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      #1 bus(1'b0, 1'b1, ADDR_CTRL, 8'h00);
      chk("ctrl reset", CTRL_RESET, rv);
      bus(1'b0, 1'b1, ADDR_STAT, 8'h00);
      chk("status reset", stat(0, 0, 0, 1, 2'h0), rv);
      bus(1'b1, 1'b0, 2'h3, 8'hFF);
      bus(1'b0, 1'b1, 2'h3, 8'h00);
      chk("unmapped", 8'h00, rv);
      // Each polarity and phase pairing once as master, each pass at its own rate
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, 1'b0, ADDR_CTRL, 8'h00);
         clock_phase_select = i[1];
         clock_polarity_select = i[0];
         bus(1'b1, 1'b0, ADDR_STAT, 8'(i));
         bus(1'b1, 1'b0, ADDR_CTRL, {2'b00, 1'b1, clock_polarity_select, clock_phase_select, 3'b010});
         idle(2);
         chk("sck idle", 8'(clock_polarity_select), 8'(pins_o.sck));
         s0 = $random(seed);
         if (i == 0) s0 = 8'hFF; // Bus/2 leaves no room for the miso synchroniser
         s1 = $random(seed);
         m0 = $random(seed);
         m1 = $random(seed);
         far_tx = s0;
         sel_n = 1'b0;
         #1 far_tx = s1;
         bus(1'b1, 1'b0, ADDR_DATA, m0);
         idle(2);
         bus(1'b0, 1'b1, ADDR_STAT, 8'h00);
         chk("tx empty", stat(0, 0, 0, 1, 2'(i)), rv);
         if (clock_phase_select) begin
            bus(1'b1, 1'b0, ADDR_DATA, m1);
            bus(1'b0, 1'b1, ADDR_STAT, 8'h00);
            chk("tx queued", stat(0, 0, 0, 0, 2'(i)), rv);
            poll(STAT_OVR_POS);
            chk("overrun", stat(1, 1, 0, 1, 2'(i)), rv);
            idle(300);
            bus(1'b0, 1'b1, ADDR_DATA, 8'h00);
            chk("kept byte", s0, rv);
            chk("far rx", m1, far_rx);
         end else begin
            poll(STAT_RXFULL_POS);
            bus(1'b0, 1'b1, ADDR_DATA, 8'h00);
            chk("rx byte", s0, rv);
            chk("far rx", m0, far_rx);
         end
         bus(1'b0, 1'b1, ADDR_STAT, 8'h00);
         chk("flags clear", stat(0, 0, 0, 1, 2'(i)), rv);
         sel_n = 1'b1;
      end
      // Slave, phase 0: a mid-frame write waits for the next frame
      bus(1'b1, 1'b0, ADDR_CTRL, 8'h00);
      bus(1'b1, 1'b0, ADDR_CTRL, 8'h02);
      bus(1'b1, 1'b0, ADDR_DATA, 8'hA5);
      idle(3);
      m0 = $random(seed);
      m1 = $random(seed);
      slv(8'hA5, m0, 1'b1);
      slv(8'h3C, m1, 1'b0);
      // Select pulled low against a master
      bus(1'b1, 1'b0, ADDR_CTRL, 8'h00);
      bus(1'b1, 1'b0, ADDR_CTRL, 8'h23);
      idle(3);
      lk_ss_n = 1'b0;
      idle(6);
      bus(1'b0, 1'b1, ADDR_STAT, 8'h00);
      chk("mode fault", stat(0, 0, 1, 1, 2'h3), rv);
      bus(1'b0, 1'b1, ADDR_CTRL, 8'h00);
      chk("fault disable", 8'h21, rv);
      idle(1);
      conclude();
   end
endmodule
